// [mbts_client.sv]
`timescale 1ns/1ps
module mbts_client (
  input wire logic clock,
  input wire logic rst,
  mbts_link_if.client link,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [7:0] cmd_fc,
  input wire logic [15:0] cmd_item,
  input wire logic [15:0] cmd_qty,
  output logic cmd_reject,
  input wire logic word_valid,
  output logic word_ready,
  input wire logic [15:0] word_data,
  output logic ans_valid,
  output logic [7:0] ans_data,
  output logic ans_last,
  output logic ans_error
);

  // ==========================================================================
  // State
  // ==========================================================================
  typedef enum logic [1:0] {
    MBTS_IDLE = 2'b00,
    MBTS_SEND = 2'b01,
    MBTS_WAIT = 2'b11
  } mbts_cli_state_t;

  typedef struct packed {
    mbts_cli_state_t state;
    logic [7:0] fc;
    logic [15:0] addr;
    logic [15:0] qty;
    logic [7:0] pos;
    logic [7:0] len;
    logic [7:0] obyte;
    logic have;
    logic [7:0] hold;
    logic reject;
    logic ans_valid;
    logic [7:0] ans_data;
    logic ans_last;
    logic ans_error;
    logic first;
  } mbts_cli_t;

  mbts_cli_t r;
  mbts_cli_t next_r;

  // Reports whether a request byte position is the high byte of a data word.
  function automatic logic is_word_hi(input logic [7:0] fc, input logic [7:0] pos);
    return (fc == mbts_pkg::FC_WR_REGS) && (pos >= mbts_pkg::POS_DATA) && !pos[0];
  endfunction

  // Forms a header byte of the request held in r, or the held low byte of a data word.
  function automatic logic [7:0] req_byte(input logic [7:0] pos);
    unique case (pos)
      mbts_pkg::POS_FC: return r.fc;
      mbts_pkg::POS_AH: return r.addr[15:8];
      mbts_pkg::POS_AL: return r.addr[7:0];
      mbts_pkg::POS_QH: return r.qty[15:8];
      mbts_pkg::POS_QL: return r.qty[7:0];
      mbts_pkg::POS_BC: return {r.qty[6:0], 1'b0};
      default: return r.hold;
    endcase
  endfunction

  // ==========================================================================
  // Outputs
  // ==========================================================================
  // Request bytes come from a flop; data words are pulled only when needed.
  assign cmd_ready = (r.state == MBTS_IDLE);
  assign word_ready = (r.state == MBTS_SEND) && !r.have;
  assign link.req_valid = (r.state == MBTS_SEND) && r.have;
  assign link.req_data = r.obyte;
  assign link.req_last = (r.pos + 8'h01 == r.len);
  assign link.rsp_ready = (r.state == MBTS_WAIT);
  assign cmd_reject = r.reject;
  assign ans_valid = r.ans_valid;
  assign ans_data = r.ans_data;
  assign ans_last = r.ans_last;
  assign ans_error = r.ans_error;

  // ==========================================================================
  // Next state
  // ==========================================================================
  // Takes a command, sends the request, then hands back each answer byte.
  always_comb begin
    logic ok;
    logic [15:0] lim;
    ok = 1'b0;
    lim = 16'h0000;
    next_r = r;
    next_r.reject = 1'b0;
    next_r.ans_valid = 1'b0;
    unique case (r.state)
      MBTS_IDLE: begin
        unique case (cmd_fc)
          mbts_pkg::FC_RD_COILS, mbts_pkg::FC_RD_DINS: lim = mbts_pkg::MAX_BITS;
          mbts_pkg::FC_RD_HREGS, mbts_pkg::FC_RD_IREGS: lim = mbts_pkg::MAX_RREGS;
          mbts_pkg::FC_WR_REGS: lim = mbts_pkg::MAX_WREGS;
          default: lim = 16'hFFFF;
        endcase
        ok = mbts_pkg::is_supported(cmd_fc) && cmd_item != 16'h0000 &&
             (cmd_fc == mbts_pkg::FC_WR_REG || (cmd_qty != 16'h0000 && cmd_qty <= lim));
        if (cmd_valid && !ok) next_r.reject = 1'b1;
        if (cmd_valid && ok) begin
          next_r.fc = cmd_fc;
          next_r.addr = cmd_item - 16'h0001;
          next_r.qty = cmd_qty;
          next_r.len = (cmd_fc == mbts_pkg::FC_WR_REGS) ?
                       (mbts_pkg::POS_DATA + {cmd_qty[6:0], 1'b0}) : mbts_pkg::HDR_LEN;
          next_r.pos = 8'h00;
          next_r.obyte = cmd_fc;
          next_r.have = 1'b1;
          next_r.state = MBTS_SEND;
        end
      end
      MBTS_SEND: begin
        if (!r.have) begin
          if (word_valid) begin
            next_r.obyte = word_data[15:8];
            next_r.hold = word_data[7:0];
            next_r.have = 1'b1;
          end
        end else if (link.req_ready) begin
          next_r.pos = r.pos + 8'h01;
          if (r.pos + 8'h01 == r.len) begin
            next_r.state = MBTS_WAIT;
            next_r.have = 1'b0;
            next_r.first = 1'b1;
          end else if (is_word_hi(r.fc, r.pos + 8'h01)) begin
            next_r.have = 1'b0;
          end else begin
            next_r.obyte = req_byte(r.pos + 8'h01);
          end
        end
      end
      MBTS_WAIT: begin
        if (link.rsp_valid) begin
          next_r.ans_valid = 1'b1;
          next_r.ans_data = link.rsp_data;
          next_r.ans_last = link.rsp_last;
          if (r.first) next_r.ans_error = link.rsp_data[7];
          next_r.first = 1'b0;
          if (link.rsp_last) next_r.state = MBTS_IDLE;
        end
      end
      default: next_r.state = MBTS_IDLE;
    endcase
  end

  // ==========================================================================
  // Register
  // ==========================================================================
  // Stores the state copy, clearing it on reset.
  always_ff @(posedge clock) begin
    if (rst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

endmodule

// [mbts_link_if.sv]
`timescale 1ns/1ps
// Byte streams carrying request and response PDUs between client and server.
interface mbts_link_if;
  logic req_valid;
  logic req_ready;
  logic [7:0] req_data;
  logic req_last;
  logic rsp_valid;
  logic rsp_ready;
  logic [7:0] rsp_data;
  logic rsp_last;

  modport server (
    input req_valid, req_data, req_last, rsp_ready,
    output req_ready, rsp_valid, rsp_data, rsp_last
  );
  modport client (
    output req_valid, req_data, req_last, rsp_ready,
    input req_ready, rsp_valid, rsp_data, rsp_last
  );
endinterface

// [mbts_link_props.sv]
`timescale 1ns/1ps
// ==========
// Link checker
// ==========
// Watches the request and response streams of one client-server link.
module mbts_link_props (
  input wire logic clock,
  input wire logic rst,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic [7:0] req_data,
  input wire logic req_last,
  input wire logic rsp_valid,
  input wire logic rsp_ready,
  input wire logic [7:0] rsp_data,
  input wire logic rsp_last
);
  logic [7:0] rq, rs, fc;
  logic [15:0] qty;
  logic err;
  wire rq_t = req_valid && req_ready;
  wire rs_t = rsp_valid && rsp_ready;

  // Tracks byte positions and keeps the function code and quantity of the current request.
  always_ff @(posedge clock) begin
    if (rst) begin
      rq <= 8'h00;
      rs <= 8'h00;
      fc <= 8'h00;
      qty <= 16'h0000;
      err <= 1'b0;
    end else begin
      if (rq_t) begin
        rq <= req_last ? 8'h00 : rq + 8'h01;
        if (rq == 8'h00) fc <= req_data;
        if (rq == 8'h03) qty[15:8] <= req_data;
        if (rq == 8'h04) qty[7:0] <= req_data;
      end
      if (rs_t) begin
        rs <= rsp_last ? 8'h00 : rs + 8'h01;
        if (rs == 8'h00) err <= rsp_data[7];
      end
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  sequence last_taken;
    rq_t && req_last;
  endsequence
  sequence head(logic [7:0] c);
    rs_t && rs == 8'h00 && rsp_data == c;
  endsequence

  answer_delay_a: assert property (last_taken |=> !rsp_valid ##1 rsp_valid)
    else $error("response did not start two cycles after the request");
  hold_off_a: assert property (last_taken |=> !req_ready until_with (rs_t && rsp_last))
    else $error("request taken while a response was pending");
  answer_bound_a: assert property (last_taken |-> ##[3:600] (rs_t && rsp_last))
    else $error("response did not finish in time");
  head_code_a: assert property (rsp_valid && rs == 8'h00 |->
    rsp_data == fc || rsp_data == (fc | 8'h80))
    else $error("first response byte does not match the function code");
  err_frame_a: assert property (head(fc | 8'h80) |=>
    rsp_valid && rsp_last && rsp_data inside {8'h01, 8'h02, 8'h03})
    else $error("error frame is malformed");
  bit_count_a: assert property (head(fc) ##0 fc inside {8'h01, 8'h02} |=>
    rsp_data == 8'((qty + 16'h0007) >> 3))
    else $error("bit read byte count wrong");
  reg_count_a: assert property (head(fc) ##0 fc inside {8'h03, 8'h04} |=>
    rsp_data == 8'(qty << 1))
    else $error("register read byte count wrong");
  read_len_a: assert property (rs_t && rsp_last && !err && fc inside {[8'h01:8'h04]} |->
    rs == (fc >= 8'h03 ? 8'(2 * qty + 1) : 8'((qty + 16'h0007) / 8 + 1)))
    else $error("read response length wrong");
endmodule

// [mbts_pkg.sv]
package mbts_pkg;

  // ==========================================================================
  // Service and function codes
  // ==========================================================================
  localparam logic [15:0] TCP_PORT = 16'h01F6;
  localparam logic [7:0] FC_RD_COILS = 8'h01;
  localparam logic [7:0] FC_RD_DINS = 8'h02;
  localparam logic [7:0] FC_RD_HREGS = 8'h03;
  localparam logic [7:0] FC_RD_IREGS = 8'h04;
  localparam logic [7:0] FC_WR_REG = 8'h06;
  localparam logic [7:0] FC_WR_REGS = 8'h10;
  localparam logic [7:0] ERR_FLAG = 8'h80;

  // ==========================================================================
  // Exception codes and limits
  // ==========================================================================
  localparam logic [7:0] EXC_NONE = 8'h00;
  localparam logic [7:0] EXC_FUNC = 8'h01;
  localparam logic [7:0] EXC_ADDR = 8'h02;
  localparam logic [7:0] EXC_QTY = 8'h03;
  localparam logic [15:0] MAX_BITS = 16'h07D0;
  localparam logic [15:0] MAX_RREGS = 16'h007D;
  localparam logic [15:0] MAX_WREGS = 16'h007B;

  // ==========================================================================
  // Byte positions and frame lengths
  // ==========================================================================
  localparam logic [7:0] POS_FC = 8'h00;
  localparam logic [7:0] POS_AH = 8'h01;
  localparam logic [7:0] POS_AL = 8'h02;
  localparam logic [7:0] POS_QH = 8'h03;
  localparam logic [7:0] POS_QL = 8'h04;
  localparam logic [7:0] POS_BC = 8'h05;
  localparam logic [7:0] POS_DATA = 8'h06;
  localparam logic [7:0] HDR_LEN = 8'h05;
  localparam logic [7:0] ERR_LEN = 8'h02;
  localparam logic [7:0] RSP_HDR = 8'h02;

  // Reports whether a function code is one the server answers normally.
  function automatic logic is_supported(input logic [7:0] fc);
    return (fc == FC_RD_COILS) || (fc == FC_RD_DINS) || (fc == FC_RD_HREGS) ||
           (fc == FC_RD_IREGS) || (fc == FC_WR_REG) || (fc == FC_WR_REGS);
  endfunction

endpackage

// [mbts_server.sv]
`timescale 1ns/1ps
module mbts_server #(
  parameter int NUM_COILS = 64,
  parameter int NUM_INPUTS = 64,
  parameter int NUM_HREGS = 32,
  parameter int NUM_IREGS = 32,
  parameter logic [15:0] LISTEN_PORT = mbts_pkg::TCP_PORT
) (
  input wire logic clock,
  input wire logic rst,
  mbts_link_if.server link,
  output logic [15:0] listen_port,
  input wire logic [NUM_COILS-1:0] coil_state,
  input wire logic [NUM_INPUTS-1:0] input_state,
  input wire logic [NUM_HREGS*16-1:0] hreg_image,
  input wire logic [NUM_IREGS*16-1:0] ireg_image,
  output logic wr_valid,
  output logic [15:0] wr_addr,
  output logic [15:0] wr_data
);

  // ==========================================================================
  // Elaboration checks
  // ==========================================================================
  if (NUM_COILS < 1 || NUM_COILS > 65535 || NUM_INPUTS < 1 || NUM_INPUTS > 65535)
    $error("Bit image sizes must lie from 1 to 65535.");
  if (NUM_HREGS < 1 || NUM_HREGS > 65535 || NUM_IREGS < 1 || NUM_IREGS > 65535)
    $error("Register image sizes must lie from 1 to 65535.");

  // ==========================================================================
  // State
  // ==========================================================================
  typedef enum logic [1:0] {
    MBTS_RECV = 2'b00,
    MBTS_CHECK = 2'b01,
    MBTS_SEND = 2'b11
  } mbts_srv_state_t;

  typedef struct packed {
    mbts_srv_state_t state;
    logic [7:0] cnt;
    logic [7:0] fc;
    logic [15:0] addr;
    logic [15:0] qty;
    logic [7:0] bcnt;
    logic [7:0] hold;
    logic wok;
    logic [15:0] widx;
    logic [7:0] exc;
    logic [7:0] len;
    logic [7:0] obyte;
    logic olast;
    logic wr_valid;
    logic [15:0] wr_addr;
    logic [15:0] wr_data;
  } mbts_srv_t;

  mbts_srv_t r;
  mbts_srv_t next_r;

  // ==========================================================================
  // Functions
  // ==========================================================================
  // Checks the header fields, returning an exception code or none.
  function automatic logic [7:0] hdr_exc(input logic [7:0] fc, input logic [15:0] addr,
                                         input logic [15:0] qty, input logic [7:0] bc);
    int lim;
    int top;
    lim = 0;
    top = int'(addr) + int'(qty);
    if (!mbts_pkg::is_supported(fc)) return mbts_pkg::EXC_FUNC;
    unique case (fc)
      mbts_pkg::FC_RD_COILS: lim = NUM_COILS;
      mbts_pkg::FC_RD_DINS: lim = NUM_INPUTS;
      mbts_pkg::FC_RD_IREGS: lim = NUM_IREGS;
      default: lim = NUM_HREGS;
    endcase
    if (fc == mbts_pkg::FC_WR_REG) top = int'(addr) + 1;
    if (fc == mbts_pkg::FC_RD_COILS || fc == mbts_pkg::FC_RD_DINS) begin
      if (qty == 16'h0000 || qty > mbts_pkg::MAX_BITS) return mbts_pkg::EXC_QTY;
    end else if (fc == mbts_pkg::FC_RD_HREGS || fc == mbts_pkg::FC_RD_IREGS) begin
      if (qty == 16'h0000 || qty > mbts_pkg::MAX_RREGS) begin
        return mbts_pkg::EXC_QTY;
      end
    end else if (fc == mbts_pkg::FC_WR_REGS) begin
      if (qty == 16'h0000 || qty > mbts_pkg::MAX_WREGS || {qty[6:0], 1'b0} != bc) begin
        return mbts_pkg::EXC_QTY;
      end
    end
    if (addr == 16'h0000 || top > lim) return mbts_pkg::EXC_ADDR;
    return mbts_pkg::EXC_NONE;
  endfunction

  // Forms response byte pos for the request held in r and the given exception.
  function automatic logic [7:0] rsp_byte(input logic [7:0] pos, input logic [7:0] exc);
    logic [7:0] b;
    int k;
    int item;
    int ri;
    b = 8'h00;
    k = int'(pos) - int'(mbts_pkg::RSP_HDR);
    ri = int'(r.addr) + k / 2;
    if (exc != mbts_pkg::EXC_NONE) begin
      b = (pos == mbts_pkg::POS_FC) ? (r.fc | mbts_pkg::ERR_FLAG) : exc;
    end else if (pos == mbts_pkg::POS_FC) begin
      b = r.fc;
    end else if (r.fc == mbts_pkg::FC_WR_REG || r.fc == mbts_pkg::FC_WR_REGS) begin
      unique case (pos)
        mbts_pkg::POS_AH: b = r.addr[15:8];
        mbts_pkg::POS_AL: b = r.addr[7:0];
        mbts_pkg::POS_QH: b = r.qty[15:8];
        default: b = r.qty[7:0];
      endcase
    end else if (r.fc == mbts_pkg::FC_RD_COILS || r.fc == mbts_pkg::FC_RD_DINS) begin
      if (pos == mbts_pkg::POS_AH) begin
        b = 8'((int'(r.qty) + 7) / 8);
      end else begin
        for (int j = 0; j < 8; j++) begin
          item = int'(r.addr) + k * 8 + j;
          if (k * 8 + j < int'(r.qty)) begin
            if (r.fc == mbts_pkg::FC_RD_COILS) begin
              b[j] = (item < NUM_COILS) ? coil_state[item] : 1'b0;
            end else begin
              b[j] = (item < NUM_INPUTS) ? input_state[item] : 1'b0;
            end
          end else begin
            b[j] = 1'b0;
          end
        end
      end
    end else if (pos == mbts_pkg::POS_AH) begin
      b = {r.qty[6:0], 1'b0};
    end else if (r.fc == mbts_pkg::FC_RD_HREGS) begin
      if (ri < NUM_HREGS) b = k[0] ? hreg_image[ri*16 +: 8] : hreg_image[ri*16+8 +: 8];
    end else begin
      if (ri < NUM_IREGS) b = k[0] ? ireg_image[ri*16 +: 8] : ireg_image[ri*16+8 +: 8];
    end
    return b;
  endfunction

  // ==========================================================================
  // Outputs
  // ==========================================================================
  // The server only ever answers; it has no way to start a request.
  assign link.req_ready = (r.state == MBTS_RECV);
  assign link.rsp_valid = (r.state == MBTS_SEND);
  assign link.rsp_data = r.obyte;
  assign link.rsp_last = r.olast;
  assign listen_port = LISTEN_PORT;
  assign wr_valid = r.wr_valid;
  assign wr_addr = r.wr_addr;
  assign wr_data = r.wr_data;

  // ==========================================================================
  // Next state
  // ==========================================================================
  // Collects the request, checks it, then streams the answer byte by byte.
  always_comb begin
    logic [7:0] x;
    logic [7:0] len_need;
    x = link.req_data;
    len_need = 8'h00;
    next_r = r;
    next_r.wr_valid = 1'b0;
    unique case (r.state)
      MBTS_RECV: begin
        if (link.req_valid) begin
          unique case (r.cnt)
            mbts_pkg::POS_FC: next_r.fc = x;
            mbts_pkg::POS_AH: next_r.addr[15:8] = x;
            mbts_pkg::POS_AL: next_r.addr[7:0] = x;
            mbts_pkg::POS_QH: next_r.qty[15:8] = x;
            mbts_pkg::POS_QL: next_r.qty[7:0] = x;
            mbts_pkg::POS_BC: begin
              next_r.bcnt = x;
              next_r.wok = (r.fc == mbts_pkg::FC_WR_REGS) &&
                           (hdr_exc(r.fc, r.addr, r.qty, x) == mbts_pkg::EXC_NONE);
            end
            default: begin
              // Multiple-register data is written word by word as it arrives.
              if (r.wok && r.widx < r.qty) begin
                if (!r.cnt[0]) begin
                  next_r.hold = x;
                end else begin
                  next_r.wr_valid = 1'b1;
                  next_r.wr_addr = r.addr + r.widx;
                  next_r.wr_data = {r.hold, x};
                  next_r.widx = r.widx + 16'h0001;
                end
              end
            end
          endcase
          if (r.cnt != 8'hFF) next_r.cnt = r.cnt + 8'h01;
          if (link.req_last) next_r.state = MBTS_CHECK;
        end
      end
      MBTS_CHECK: begin
        next_r.exc = hdr_exc(r.fc, r.addr, r.qty, r.bcnt);
        len_need = (r.fc == mbts_pkg::FC_WR_REGS) ? (mbts_pkg::POS_DATA + r.bcnt) :
                   mbts_pkg::HDR_LEN;
        if (next_r.exc == mbts_pkg::EXC_NONE && r.cnt != len_need) begin
          next_r.exc = mbts_pkg::EXC_QTY;
        end
        if (next_r.exc != mbts_pkg::EXC_NONE) begin
          next_r.len = mbts_pkg::ERR_LEN;
        end else if (r.fc == mbts_pkg::FC_RD_COILS || r.fc == mbts_pkg::FC_RD_DINS) begin
          next_r.len = mbts_pkg::RSP_HDR + 8'((int'(r.qty) + 7) / 8);
        end else if (r.fc == mbts_pkg::FC_RD_HREGS || r.fc == mbts_pkg::FC_RD_IREGS) begin
          next_r.len = mbts_pkg::RSP_HDR + {r.qty[6:0], 1'b0};
        end else begin
          next_r.len = mbts_pkg::HDR_LEN;
        end
        if (next_r.exc == mbts_pkg::EXC_NONE && r.fc == mbts_pkg::FC_WR_REG) begin
          next_r.wr_valid = 1'b1;
          next_r.wr_addr = r.addr;
          next_r.wr_data = r.qty;
        end
        next_r.cnt = 8'h00;
        next_r.obyte = rsp_byte(8'h00, next_r.exc);
        next_r.olast = 1'b0;
        next_r.state = MBTS_SEND;
      end
      MBTS_SEND: begin
        if (link.rsp_ready) begin
          if (r.olast) begin
            next_r.state = MBTS_RECV;
            next_r.cnt = 8'h00;
            next_r.wok = 1'b0;
            next_r.widx = 16'h0000;
            next_r.bcnt = 8'h00;
          end else begin
            next_r.cnt = r.cnt + 8'h01;
            next_r.obyte = rsp_byte(r.cnt + 8'h01, r.exc);
            next_r.olast = (r.cnt + 8'h02 == r.len);
          end
        end
      end
      default: next_r.state = MBTS_RECV;
    endcase
  end

  // ==========================================================================
  // Register
  // ==========================================================================
  // Stores the state copy, clearing it on reset.
  always_ff @(posedge clock) begin
    if (rst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

endmodule

// [tb.sv]
`timescale 1ns/1ps
// ==========
// Testbench
// ==========
module tb;
  logic clock, rst, cmd_valid, cmd_ready, cmd_reject, word_valid, word_ready;
  logic ans_valid, ans_last, ans_error, wr_valid, rej, err, widx;
  logic [7:0] cmd_fc, ans_data;
  logic [15:0] cmd_item, cmd_qty, word_data, wr_addr, wr_data, port, la, ld;
  logic [63:0] coil_state, input_state;
  logic [511:0] hreg_image, ireg_image;
  logic [15:0] wl [2];
  logic [7:0] got [$];
  logic [7:0] exp [$];
  int fails, n_compared, n_wr;
  localparam logic [39:0] RD [9] = '{40'h01_0002_0003, 40'h01_000A_0009, 40'h01_0039_0008,
    40'h02_0003_000B, 40'h02_0002_0010, 40'h03_0002_0003, 40'h03_001E_0003,
    40'h04_0004_0002, 40'h04_0002_0001};
  localparam logic [47:0] EX [3] = '{48'h03_001F_0003_02, 48'h01_0040_0002_02,
    48'h02_0002_07D0_02};
  localparam logic [39:0] RF [4] = '{40'h05_0002_0001, 40'h01_0002_0000,
    40'h01_0002_07D1, 40'h03_0002_007E};
  localparam logic [55:0] RW [8] = '{56'h05_0001_0001_8501, 56'h01_0001_0000_8103,
    56'h01_0001_07D1_8103, 56'h03_0001_007E_8303, 56'h02_0000_0001_8202,
    56'h04_0000_0001_8402, 56'h10_0001_0001_9003, 56'h06_0020_0001_8602};

  mbts_link_if link();
  mbts_link_if l2();

  mbts_server mbts_server_i (.clock(clock), .rst(rst), .link(link), .listen_port(port),
    .coil_state(coil_state), .input_state(input_state), .hreg_image(hreg_image),
    .ireg_image(ireg_image), .wr_valid(wr_valid), .wr_addr(wr_addr), .wr_data(wr_data));
  mbts_server mbts_server_i2 (.clock(clock), .rst(rst), .link(l2), .listen_port(),
    .coil_state(coil_state), .input_state(input_state), .hreg_image(hreg_image),
    .ireg_image(ireg_image), .wr_valid(), .wr_addr(), .wr_data());
  mbts_client mbts_client_i (.clock(clock), .rst(rst), .link(link), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_fc(cmd_fc), .cmd_item(cmd_item), .cmd_qty(cmd_qty),
    .cmd_reject(cmd_reject), .word_valid(word_valid), .word_ready(word_ready),
    .word_data(word_data), .ans_valid(ans_valid), .ans_data(ans_data),
    .ans_last(ans_last), .ans_error(ans_error));
  mbts_link_props mbts_link_props_i (.clock(clock), .rst(rst), .req_valid(link.req_valid),
    .req_ready(link.req_ready), .req_data(link.req_data), .req_last(link.req_last),
    .rsp_valid(link.rsp_valid), .rsp_ready(link.rsp_ready), .rsp_data(link.rsp_data),
    .rsp_last(link.rsp_last));

  // Makes the 200 MHz clock.
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  // Supplies write words in turn and records write pulses of the server.
  assign word_data = wl[widx];
  always @(posedge clock) begin
    if (word_valid === 1'b1 && word_ready === 1'b1) widx <= ~widx;
    if (wr_valid === 1'b1) begin
      n_wr++;
      la = wr_addr;
      ld = wr_data;
    end
  end

  // Counts a comparison and reports a mismatch.
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] want);
    n_compared++;
    if (seen !== want) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, want, seen);
    end
  endtask

  // Compares the collected answer with the expected bytes.
  task automatic cmp_q();
    check("length", 16'(got.size()), 16'(exp.size()));
    foreach (exp[i]) begin
      if (i < got.size()) check("byte", {8'h00, got[i]}, {8'h00, exp[i]});
    end
  endtask

  // Gives one command to the client and collects the answer bytes.
  task automatic run(input logic [7:0] fc, input logic [15:0] item, input logic [15:0] qty);
    got.delete();
    cmd_fc = fc;
    cmd_item = item;
    cmd_qty = qty;
    cmd_valid = 1'b1;
    @(posedge clock);
    while (cmd_ready !== 1'b1) @(posedge clock);
    #1;
    cmd_valid = 1'b0;
    rej = cmd_reject;
    @(posedge clock);
    #1;
    rej = rej | cmd_reject;
    if (rej !== 1'b1) begin
      do begin
        @(posedge clock);
        #1;
        if (ans_valid === 1'b1) got.push_back(ans_data);
      end while (!(ans_valid === 1'b1 && ans_last === 1'b1));
      err = ans_error;
    end
  endtask

  // Works out a read answer from the images; the item is one above the address.
  task automatic exp_read(input logic [7:0] fc, input int item, input int qty);
    logic [7:0] b;
    logic [15:0] w;
    exp = '{fc};
    if (fc < 8'h03) begin
      exp.push_back(8'((qty + 7) / 8));
      for (int k = 0; k < (qty + 7) / 8; k++) begin
        b = 8'h00;
        for (int j = 0; j < 8; j++) if (8 * k + j < qty)
          b[j] = fc == 8'h01 ? coil_state[item - 1 + 8 * k + j] :
                 input_state[item - 1 + 8 * k + j];
        exp.push_back(b);
      end
    end else begin
      exp.push_back(8'(2 * qty));
      for (int i = 0; i < qty; i++) begin
        w = fc == 8'h03 ? hreg_image[(item - 1 + i) * 16 +: 16] :
            ireg_image[(item - 1 + i) * 16 +: 16];
        exp.push_back(w[15:8]);
        exp.push_back(w[7:0]);
      end
    end
  endtask

  // Sends one raw five-byte request to the second server and checks its two-byte answer.
  task automatic raw(input logic [55:0] t);
    logic [15:0] g;
    for (int i = 0; i < 5; i++) begin
      l2.req_valid = 1'b1;
      l2.req_data = t[55 - 8 * i -: 8];
      l2.req_last = (i == 4);
      @(posedge clock);
      while (l2.req_ready !== 1'b1) @(posedge clock);
      #1;
    end
    l2.req_valid = 1'b0;
    l2.req_data = ~l2.req_data;
    l2.rsp_ready = 1'b1;
    do begin
      @(posedge clock);
      if (l2.rsp_valid === 1'b1) g = {g[7:0], l2.rsp_data};
    end while (!(l2.rsp_valid === 1'b1 && l2.rsp_last === 1'b1));
    #1;
    l2.rsp_ready = 1'b0;
    check("raw answer", g, t[15:0]);
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Cuts a hang short.
  initial begin
    #200000;
    fails++;
    stop_test();
  end

  // Main sequence.
  initial begin
    rst = 1'b1;
    {cmd_valid, cmd_fc, cmd_item, cmd_qty, widx, n_wr, fails, n_compared} = '0;
    word_valid = 1'b1;
    wl = '{16'h1234, 16'hABCD};
    {l2.req_valid, l2.req_data, l2.req_last, l2.rsp_ready} = '0;
    coil_state = 64'hF0E1_D2C3_B4A5_9687;
    input_state = 64'h0123_4567_89AB_CDEF;
    for (int i = 0; i < 32; i++) begin
      hreg_image[i * 16 +: 16] = 16'h022B + 16'(i) * 16'h0111;
      ireg_image[i * 16 +: 16] = 16'hA5C3 ^ 16'(i * 16'h1357);
    end
    repeat (16) @(posedge clock);
    #1;
    rst = 1'b0;
    check("port", port, 16'h01F6);
    foreach (RD[i]) begin
      run(RD[i][39:32], RD[i][31:16], RD[i][15:0]);
      exp_read(RD[i][39:32], RD[i][31:16], RD[i][15:0]);
      cmp_q();
      check("error flag", {15'h0000, err}, 16'h0000);
    end
    foreach (EX[i]) begin
      run(EX[i][47:40], EX[i][39:24], EX[i][23:8]);
      exp = '{EX[i][47:40] | 8'h80, EX[i][7:0]};
      cmp_q();
      check("error flag", {15'h0000, err}, 16'h0001);
    end
    foreach (RF[i]) begin
      run(RF[i][39:32], RF[i][31:16], RF[i][15:0]);
      check("refused", {15'h0000, rej}, 16'h0001);
    end
    run(8'h06, 16'h0005, 16'h022B);
    exp = '{8'h06, 8'h00, 8'h04, 8'h02, 8'h2B};
    cmp_q();
    check("write count", 16'(n_wr), 16'h0001);
    check("write address", la, 16'h0004);
    check("write data", ld, 16'h022B);
    run(8'h10, 16'h0003, 16'h0002);
    exp = '{8'h10, 8'h00, 8'h02, 8'h00, 8'h02};
    cmp_q();
    check("write count", 16'(n_wr), 16'h0003);
    check("write address", la, 16'h0003);
    check("write data", ld, 16'hABCD);
    foreach (RW[i]) raw(RW[i]);
    stop_test();
  end
endmodule
